// [rtl/sea_pkg.sv]
// constants for the slave-bus eeprom access command handler
package sea_pkg;
	// byte positions within a command sequence
	localparam logic [2:0] POS_SLAVE_COMMAND_CODE     = 3'h0;
	localparam logic [2:0] POS_COUNT     = 3'h1;
	localparam logic [2:0] POS_CMD       = 3'h2;
	localparam logic [2:0] POS_BUSADDR   = 3'h3;
	localparam logic [2:0] POS_OFS_LOW   = 3'h4;
	localparam logic [2:0] POS_OFS_HIGH  = 3'h5;
	localparam logic [2:0] POS_DATA      = 3'h6;
	// command byte field positions
	localparam int BIT_RW_SELECT  = 0;
	localparam int BIT_USE_ADDR   = 1;
	localparam int BIT_NACK_ERR   = 3;
	localparam int BIT_ARB_ERR    = 4;
	localparam int BIT_FRAME_ERR  = 5;
	// bytes following the command code byte in a full sequence, count byte included
	localparam logic [7:0] SEQ_FOLLOW_COUNT = 8'h06;
	// arbitration losses in a row that count as an error
	localparam logic [4:0] ARB_LOSS_LIMIT   = 5'h10;
	localparam logic [7:0] BYTE_RESET       = 8'h00;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RECV  = 3'b001,
		ST_START = 3'b010,
		ST_WAIT  = 3'b011,
		ST_SEND  = 3'b100
	} sea_state_type;
endpackage

// [rtl/sea_eeprom_access.sv]
// slave-bus command handler for single-byte eeprom access over the master bus
`timescale 1ns/100ps
// Operation
// (R1) A sequence follows the slave address and opens with the command code byte.
// (R2) The count byte is present only in block transactions, not word or byte ones.
// (R3) The host sets the count to the bytes following the count byte when writing.
// (R4) On read-back the device sends a count equal to the following bytes, status included.
// (R5) Position 2 is the command byte, position 3 the bus address used only when selected.
// (R6) The host sends the 7-bit bus address left-justified with bit zero cleared.
// (R7) Positions 4 and 5 carry the low and high offset bytes.
// (R8) Position 6 carries the data byte to write or the byte read back.
// (R9) Command bit 0 selects write when 0 and read when 1.
// (R10) Command bit 1 selects the supplied bus address instead of the configured one.
// (R11) Command bit 3 is set on an unexpected nack and cleared when read.
// (R12) Command bit 4 is set after 16 arbitration losses in a row and cleared when read.
// (R13) Command bit 5 is set on a misplaced start or stop and cleared when read.
// (R14) The three flags act exactly as the matching master bus status flags.
// (R15) The host writes zero to command bits 7:6 and bit 2.
// (R16) A read is a block write of the request followed by a block read of the result.
module sea_eeprom_access (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// byte stream from the slave bus engine
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_byte,
	input  wire logic        i_rx_block,
	input  wire logic        i_rx_end,
	// byte stream to the slave bus engine during a block read
	input  wire logic        i_tx_start,
	input  wire logic        i_tx_take,
	output logic             o_tx_valid,
	output logic [7:0]       o_tx_byte,
	// master bus engine
	input  wire logic [6:0]  i_default_eeprom_bus_address,
	output logic             o_mst_req,
	output logic             o_mst_read,
	output logic [6:0]       o_mst_bus_address,
	output logic [15:0]      o_mst_offset,
	output logic [7:0]       o_mst_wdata,
	input  wire logic        i_mst_done,
	input  wire logic [7:0]  i_mst_rdata,
	input  wire logic        i_mst_nack,
	input  wire logic        i_mst_arb_lost,
	input  wire logic        i_mst_framing,
	output logic             o_busy
);
	sea_pkg::sea_state_type state_reg;
	logic [2:0]  pos_reg;
	logic [7:0]  cmd_reg;
	logic [7:0]  bus_addr_reg;
	logic [7:0]  ofs_low_reg;
	logic [7:0]  ofs_high_reg;
	logic [7:0]  data_reg;
	logic [4:0]  arb_cnt_reg;
	logic        nack_flag_reg;
	logic        arb_flag_reg;
	logic        frame_flag_reg;
	logic [2:0]  tx_pos_reg;
	logic        tx_on_reg;
	logic        arb_limit_hit;
	logic        flags_read;
	logic [7:0]  status_byte;
	logic [7:0]  tx_next;
	logic [2:0]  rx_pos;

	// ------------------------------------------------------------
	// receive side
	// ------------------------------------------------------------
	// without the count byte the stream skips position 1
	assign rx_pos = (!i_rx_block && pos_reg == sea_pkg::POS_COUNT) ? sea_pkg::POS_CMD : pos_reg; // R2

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pos_reg      <= 3'h0;
			cmd_reg      <= sea_pkg::BYTE_RESET;
			bus_addr_reg <= sea_pkg::BYTE_RESET;
			ofs_low_reg  <= sea_pkg::BYTE_RESET;
			ofs_high_reg <= sea_pkg::BYTE_RESET;
		end else if (i_rx_end) begin
			pos_reg <= 3'h0;
		end else if (i_rx_valid && state_reg != sea_pkg::ST_WAIT) begin
			if (rx_pos != sea_pkg::POS_DATA)
				pos_reg <= rx_pos + 3'h1;
			case (rx_pos)
				sea_pkg::POS_SLAVE_COMMAND_CODE:    ; // R1
				sea_pkg::POS_COUNT:    ; // R3
				sea_pkg::POS_CMD:      cmd_reg      <= i_rx_byte; // R5
				sea_pkg::POS_BUSADDR:  bus_addr_reg <= i_rx_byte; // R5
				sea_pkg::POS_OFS_LOW:  ofs_low_reg  <= i_rx_byte; // R7
				sea_pkg::POS_OFS_HIGH: ofs_high_reg <= i_rx_byte; // R7
				default:               ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// transaction control
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= sea_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				sea_pkg::ST_IDLE:
					if (i_rx_valid)
						state_reg <= sea_pkg::ST_RECV;
				sea_pkg::ST_RECV:
					if (i_rx_end)
						state_reg <= (pos_reg == sea_pkg::POS_DATA || cmd_reg[sea_pkg::BIT_RW_SELECT])
							? sea_pkg::ST_START : sea_pkg::ST_IDLE;
				sea_pkg::ST_START:
					state_reg <= sea_pkg::ST_WAIT;
				sea_pkg::ST_WAIT:
					if (i_mst_done || arb_limit_hit)
						state_reg <= sea_pkg::ST_IDLE;
				default:
					state_reg <= sea_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mst_req         <= 1'b0;
			o_mst_read        <= 1'b0;
			o_mst_bus_address <= 7'h00;
			o_mst_offset      <= 16'h0000;
			o_mst_wdata       <= sea_pkg::BYTE_RESET;
		end else if (state_reg == sea_pkg::ST_START) begin
			o_mst_req         <= 1'b1;
			o_mst_read        <= cmd_reg[sea_pkg::BIT_RW_SELECT]; // R9
			o_mst_bus_address <= cmd_reg[sea_pkg::BIT_USE_ADDR] ? bus_addr_reg[7:1]
				: i_default_eeprom_bus_address; // R10 R6
			o_mst_offset      <= {ofs_high_reg, ofs_low_reg}; // R7
			o_mst_wdata       <= data_reg; // R8
		end else if (i_mst_done || arb_limit_hit) begin
			o_mst_req <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_busy <= 1'b0;
		else
			o_busy <= (state_reg == sea_pkg::ST_START) || (state_reg == sea_pkg::ST_WAIT);
	end

	// data byte: written value from the host, or read-back from the eeprom
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			data_reg <= sea_pkg::BYTE_RESET;
		else if (state_reg == sea_pkg::ST_WAIT && i_mst_done && o_mst_read)
			data_reg <= i_mst_rdata; // R8
		else if (i_rx_valid && rx_pos == sea_pkg::POS_DATA && state_reg != sea_pkg::ST_WAIT)
			data_reg <= i_rx_byte; // R8
	end

	// ------------------------------------------------------------
	// error flags
	// ------------------------------------------------------------
	assign arb_limit_hit = (state_reg == sea_pkg::ST_WAIT) && i_mst_arb_lost
		&& (arb_cnt_reg == sea_pkg::ARB_LOSS_LIMIT - 5'h01);
	// flags clear once the status byte has been handed out
	assign flags_read = tx_on_reg && i_tx_take && tx_pos_reg == sea_pkg::POS_CMD;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			arb_cnt_reg <= 5'h00;
		else if (state_reg != sea_pkg::ST_WAIT || arb_limit_hit || i_mst_done)
			arb_cnt_reg <= 5'h00;
		else if (i_mst_arb_lost)
			arb_cnt_reg <= arb_cnt_reg + 5'h01; // R12
	end

	// a new event in the read cycle wins over the clear
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			nack_flag_reg  <= 1'b0;
			arb_flag_reg   <= 1'b0;
			frame_flag_reg <= 1'b0;
		end else begin
			if (state_reg == sea_pkg::ST_WAIT && i_mst_nack)
				nack_flag_reg <= 1'b1; // R11 R14
			else if (flags_read)
				nack_flag_reg <= 1'b0; // R11
			if (arb_limit_hit)
				arb_flag_reg <= 1'b1; // R12 R14
			else if (flags_read)
				arb_flag_reg <= 1'b0; // R12
			if (state_reg == sea_pkg::ST_WAIT && i_mst_framing)
				frame_flag_reg <= 1'b1; // R13 R14
			else if (flags_read)
				frame_flag_reg <= 1'b0; // R13
		end
	end

	// ------------------------------------------------------------
	// block read answer
	// ------------------------------------------------------------
	always_comb begin
		status_byte = 8'h00; // R15
		status_byte[sea_pkg::BIT_RW_SELECT] = cmd_reg[sea_pkg::BIT_RW_SELECT];
		status_byte[sea_pkg::BIT_USE_ADDR]  = cmd_reg[sea_pkg::BIT_USE_ADDR];
		status_byte[sea_pkg::BIT_NACK_ERR]  = nack_flag_reg;
		status_byte[sea_pkg::BIT_ARB_ERR]   = arb_flag_reg;
		status_byte[sea_pkg::BIT_FRAME_ERR] = frame_flag_reg;
	end

	always_comb begin
		case (tx_pos_reg)
			sea_pkg::POS_SLAVE_COMMAND_CODE:    tx_next = sea_pkg::SEQ_FOLLOW_COUNT - 8'h01; // R4
			sea_pkg::POS_COUNT:    tx_next = status_byte; // R16
			sea_pkg::POS_CMD:      tx_next = bus_addr_reg;
			sea_pkg::POS_BUSADDR:  tx_next = ofs_low_reg;
			sea_pkg::POS_OFS_LOW:  tx_next = ofs_high_reg;
			sea_pkg::POS_OFS_HIGH: tx_next = data_reg; // R8
			default:               tx_next = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_on_reg  <= 1'b0;
			tx_pos_reg <= 3'h0;
			o_tx_valid <= 1'b0;
			o_tx_byte  <= sea_pkg::BYTE_RESET;
		end else if (i_tx_start) begin
			tx_on_reg  <= 1'b1;
			tx_pos_reg <= sea_pkg::POS_COUNT;
			o_tx_valid <= 1'b1;
			o_tx_byte  <= sea_pkg::SEQ_FOLLOW_COUNT - 8'h01; // R4 R16
		end else if (tx_on_reg && i_tx_take) begin
			if (tx_pos_reg == sea_pkg::POS_DATA) begin
				tx_on_reg  <= 1'b0;
				o_tx_valid <= 1'b0;
			end else begin
				tx_pos_reg <= tx_pos_reg + 3'h1;
				o_tx_byte  <= tx_next;
			end
		end
	end
endmodule

// [sim/sea_far_model.sv]
// master bus engine model answering eeprom transfers
`timescale 1ns/100ps
module sea_far_model (
	input  wire logic       i_clk,
	input  wire logic       i_req,
	input  wire logic [1:0] i_err,
	input  wire logic [3:0] i_delay,
	output logic            o_done,
	output logic            o_nack,
	output logic            o_arb,
	output logic            o_frame,
	output logic [7:0]      o_rdata
);
	initial begin
		{o_done, o_nack, o_arb, o_frame, o_rdata} = 12'h000;
		forever begin
			@(posedge i_clk iff i_req);
			repeat (i_delay) @(posedge i_clk);
			o_arb <= (i_err == 2'h2);
			o_nack <= (i_err == 2'h1);
			o_frame <= (i_err == 2'h3);
			repeat ((i_err == 2'h2) ? 16 : 1) @(posedge i_clk);
			{o_arb, o_nack, o_frame} <= 3'h0;
			o_done <= (i_err != 2'h2);
			o_rdata <= {4'ha, i_delay};
			@(posedge i_clk);
			o_done <= 1'b0;
			// read data does not hold once the answer is gone
			o_rdata <= ~o_rdata;
			@(posedge i_clk iff !i_req);
		end
	end
endmodule

// [sim/sea_eeprom_access_sva.sv]
// assertion checker for the eeprom access command handler
`timescale 1ns/100ps
module sea_eeprom_access_sva (
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	input wire logic        i_rx_end,
	input wire logic        i_tx_start,
	input wire logic        i_tx_take,
	input wire logic        i_mst_done,
	input wire logic        i_mst_arb_lost,
	input wire logic        o_tx_valid,
	input wire logic [7:0]  o_tx_byte,
	input wire logic        o_mst_req,
	input wire logic [6:0]  o_mst_bus_address,
	input wire logic [15:0] o_mst_offset,
	input wire logic        o_busy
);
	logic [4:0] arb_cnt;
	logic [2:0] tk;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) arb_cnt <= 5'h00;
		else if (!o_mst_req || i_mst_done) arb_cnt <= 5'h00;
		else if (i_mst_arb_lost) arb_cnt <= arb_cnt + 5'h01;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) tk <= 3'h0;
		else if (i_tx_start) tk <= 3'h0;
		else if (i_tx_take && o_tx_valid) tk <= tk + 3'h1;
	end
	property p_drop; o_mst_req && i_mst_done |=> !o_mst_req; endproperty
	a_drop: assert property (p_drop) else $error("request outlived done");
	property p_rise; $rose(o_mst_req) |-> $past(i_rx_end, 2); endproperty
	a_rise: assert property (p_rise) else $error("request not two edges after end");
	property p_keep; o_mst_req ##1 o_mst_req |-> $stable({o_mst_bus_address, o_mst_offset}); endproperty
	a_keep: assert property (p_keep) else $error("address moved during request");
	property p_arb; arb_cnt == 5'h10 |-> !o_mst_req; endproperty
	a_arb: assert property (p_arb) else $error("request kept after 16 losses");
	property p_cnt; i_tx_start && !o_busy |=> o_tx_valid && o_tx_byte == 8'h05; endproperty
	a_cnt: assert property (p_cnt) else $error("bad read-back count");
	property p_hold; o_tx_valid && !i_tx_take && !i_tx_start |=> o_tx_valid && $stable(o_tx_byte); endproperty
	a_hold: assert property (p_hold) else $error("tx byte not held");
	property p_rsvd; o_tx_valid && tk == 3'h1 |-> o_tx_byte[7:6] == 2'h0 && !o_tx_byte[2]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
	property p_last; o_tx_valid && i_tx_take && tk == 3'h5 |=> !o_tx_valid; endproperty
	a_last: assert property (p_last) else $error("valid after data byte");
	c_done: cover property (o_mst_req && i_mst_done);
	c_arb: cover property (arb_cnt == 5'h10);
	c_last: cover property (o_tx_valid && i_tx_take && tk == 3'h5);
endmodule
bind sea_eeprom_access sea_eeprom_access_sva sea_eeprom_access_sva_inst (
	.i_clk             (i_clk),
	.i_rst_b           (i_rst_b),
	.i_rx_end          (i_rx_end),
	.i_tx_start        (i_tx_start),
	.i_tx_take         (i_tx_take),
	.i_mst_done        (i_mst_done),
	.i_mst_arb_lost    (i_mst_arb_lost),
	.o_tx_valid        (o_tx_valid),
	.o_tx_byte         (o_tx_byte),
	.o_mst_req         (o_mst_req),
	.o_mst_bus_address (o_mst_bus_address),
	.o_mst_offset      (o_mst_offset),
	.o_busy            (o_busy)
);

// [sim/sea_eeprom_access_bench.sv]
// self-checking bench for the eeprom access command handler
`timescale 1ns/100ps
module sea_eeprom_access_bench;
	typedef struct {logic blk; logic [7:0] cmd, adr, lo, hi, dat; logic [1:0] err;
		logic [6:0] bus;} sea_row_type;
	logic        i_clk, i_rst_b, i_rx_valid, i_rx_block, i_rx_end, i_tx_start, i_tx_take;
	logic [7:0]  i_rx_byte, o_tx_byte, o_mst_wdata, i_mst_rdata;
	logic        o_tx_valid, o_mst_req, o_mst_read, i_mst_done, i_mst_nack, i_mst_arb_lost;
	logic        i_mst_framing, o_busy;
	logic [6:0]  o_mst_bus_address;
	logic [6:0]  i_default_eeprom_bus_address;
	logic [15:0] o_mst_offset;
	logic [1:0]  err_sel;
	logic [3:0]  delay_sel;
	int          errors, comparisons;
	sea_row_type r;
	sea_row_type rows [6];
	sea_eeprom_access sea_eeprom_access_inst (
		.i_clk                        (i_clk),
		.i_rst_b                      (i_rst_b),
		.i_rx_valid                   (i_rx_valid),
		.i_rx_byte                    (i_rx_byte),
		.i_rx_block                   (i_rx_block),
		.i_rx_end                     (i_rx_end),
		.i_tx_start                   (i_tx_start),
		.i_tx_take                    (i_tx_take),
		.o_tx_valid                   (o_tx_valid),
		.o_tx_byte                    (o_tx_byte),
		.i_default_eeprom_bus_address (i_default_eeprom_bus_address),
		.o_mst_req                    (o_mst_req),
		.o_mst_read                   (o_mst_read),
		.o_mst_bus_address            (o_mst_bus_address),
		.o_mst_offset                 (o_mst_offset),
		.o_mst_wdata                  (o_mst_wdata),
		.i_mst_done                   (i_mst_done),
		.i_mst_rdata                  (i_mst_rdata),
		.i_mst_nack                   (i_mst_nack),
		.i_mst_arb_lost               (i_mst_arb_lost),
		.i_mst_framing                (i_mst_framing),
		.o_busy                       (o_busy)
	);
	sea_far_model sea_far_model_inst (.i_clk(i_clk), .i_req(o_mst_req), .i_err(err_sel),
		.i_delay(delay_sel), .o_done(i_mst_done), .o_nack(i_mst_nack),
		.o_arb(i_mst_arb_lost), .o_frame(i_mst_framing), .o_rdata(i_mst_rdata));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_for(input int sel, input logic lvl);
		for (int n = 0; ((sel == 0) ? o_mst_req : (sel == 1) ? o_busy : o_tx_valid) !== lvl; n++) begin
			if (n > 200) begin
				errors++;
				report_and_stop();
			end
			@(negedge i_clk);
		end
	endtask
	task automatic send(input logic [7:0] b);
		@(negedge i_clk) i_rx_valid = 1'b1;
		i_rx_byte = b;
		@(negedge i_clk) i_rx_valid = 1'b0;
	endtask
	task automatic readback(input logic [7:0] st, ad, lo, hi, dt, input logic ckd);
		logic [7:0] e [6];
		e = '{8'h05, st, ad, lo, hi, dt};
		@(negedge i_clk) i_tx_start = 1'b1;
		@(negedge i_clk) i_tx_start = 1'b0;
		for (int k = 0; k < 6; k++) begin
			wait_for(2, 1'b1);
			if (k < 5 || ckd) chk(16'(o_tx_byte), 16'(e[k]));
			i_tx_take = 1'b1;
			@(negedge i_clk) i_tx_take = 1'b0;
		end
		chk(16'(o_tx_valid), 16'h0000);
	endtask
	initial begin
		rows = '{'{1, 8'h00, 8'ha4, 8'h10, 8'h20, 8'h3c, 0, 7'h50},
			'{0, 8'h02, 8'ha4, 8'hff, 8'hff, 8'hc3, 0, 7'h52},
			'{1, 8'h03, 8'hae, 8'h00, 8'h80, 8'h00, 0, 7'h57},
			'{1, 8'h01, 8'hae, 8'h01, 8'h00, 8'h00, 1, 7'h2d},
			'{1, 8'h03, 8'h02, 8'h7f, 8'h01, 8'h00, 3, 7'h01},
			'{1, 8'h03, 8'h1e, 8'h00, 8'h00, 8'h00, 2, 7'h0f}};
		{i_rst_b, i_rx_valid, i_rx_block, i_rx_end, i_tx_start, i_tx_take} = 6'h00;
		{i_rx_byte, err_sel, delay_sel, errors, comparisons} = '0;
		i_default_eeprom_bus_address = 7'h00;
		repeat (12) @(negedge i_clk);
		chk(16'({o_busy, o_mst_req, o_tx_valid}), 16'h0000);
		i_rst_b = 1'b1;
		foreach (rows[n]) begin
			r = rows[n];
			err_sel = r.err;
			delay_sel = 4'(n);
			// configured address differs from the supplied one whenever the latter is selected
			i_default_eeprom_bus_address = r.cmd[1] ? 7'h3c : r.bus;
			i_rx_block = r.blk;
			send(8'h00);
			if (r.blk) send(8'h06);
			send(r.cmd);
			send(r.adr);
			send(r.lo);
			send(r.hi);
			send(r.dat);
			@(negedge i_clk) i_rx_end = 1'b1;
			@(negedge i_clk) i_rx_end = 1'b0;
			wait_for(0, 1'b1);
			chk(16'(o_mst_read), 16'(r.cmd[0]));
			chk(16'(o_mst_bus_address), 16'(r.bus));
			chk(o_mst_offset, {r.hi, r.lo});
			if (!r.cmd[0]) chk(16'(o_mst_wdata), 16'(r.dat));
			wait_for(1, 1'b0);
			if (r.cmd[0]) readback(r.cmd | ((r.err == 2'h0) ? 8'h00 : (8'h04 << r.err)), r.adr,
				r.lo, r.hi, {4'ha, 4'(n)}, r.err != 2'h2);
		end
		readback(8'h03, 8'h1e, 8'h00, 8'h00, 8'h00, 1'b0);
		send(8'h00);
		send(8'h06);
		send(8'h00);
		@(negedge i_clk) i_rx_end = 1'b1;
		@(negedge i_clk) i_rx_end = 1'b0;
		repeat (6) @(negedge i_clk);
		chk(16'(o_mst_req), 16'h0000);
		// reset dropped while a read request is pending on the master bus
		delay_sel = 4'hf;
		send(8'h00);
		send(8'h06);
		send(8'h01);
		@(negedge i_clk) i_rx_end = 1'b1;
		@(negedge i_clk) i_rx_end = 1'b0;
		wait_for(0, 1'b1);
		chk(16'(o_mst_read), 16'h0001);
		i_rst_b = 1'b0;
		@(negedge i_clk) chk(16'({o_busy, o_mst_req, o_tx_valid}), 16'h0000);
		i_rst_b = 1'b1;
		repeat (3) @(negedge i_clk);
		chk(16'({o_busy, o_mst_req, o_tx_valid}), 16'h0000);
		report_and_stop();
	end
endmodule
